// File: rtl/event_counter.sv
// Cumulative, clearable counters of output rising edges.
`timescale 1ns/1ns
module event_counter (
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic [heat_guard_pkg::NUM_EVENTS-1:0] rise,
    input  wire logic [heat_guard_pkg::NUM_EVENTS-1:0] clear,
    input  wire logic [2:0]                           sel,
    output logic [31:0]                               count
);
    logic [31:0] cnt [heat_guard_pkg::NUM_EVENTS];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < heat_guard_pkg::NUM_EVENTS; i++) begin
                cnt[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < heat_guard_pkg::NUM_EVENTS; i++) begin
                // A new occurrence in the clear cycle counts as one.
                if (clear[i]) begin
                    cnt[i] <= {31'h0000_0000, rise[i]};
                end else if (rise[i]) begin
                    cnt[i] <= cnt[i] + 32'h0000_0001;
                end
            end
        end
    end

    assign count = (int'(sel) < heat_guard_pkg::NUM_EVENTS) ? cnt[sel] : 32'h0000_0000;
endmodule

// File: rtl/machine_heat_guard.sv
// Control and I/O shell of the machine heat guard.
`timescale 1ns/1ns
module machine_heat_guard (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire heat_guard_pkg::meas_t meas,
    input  wire logic                  meas_tick,
    input  wire logic                  block_in,
    input  wire heat_guard_pkg::reg_req_t bus,
    output logic [31:0]                rdata,
    output heat_guard_pkg::event_t     event_out,
    output logic                       trip,
    output logic                       alarm1,
    output logic                       alarm2,
    output logic                       lockout,
    output logic                       blocked,
    output logic [15:0]                heat_temp,
    output logic                       irq
);
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_REPLICA = 5'b00010,
        ST_COMPARE = 5'b00100,
        ST_BLOCK   = 5'b01000,
        ST_OUTPUT  = 5'b10000
    } stage_t;

    localparam int HEAT_W_L = heat_guard_pkg::HEAT_W;
    logic                  rst_meta;
    logic                  rst_sync;
    logic                  tick_meta;
    logic                  tick_sync;
    logic                  tick_prev;
    logic                  block_meta;
    logic                  block_sync;
    stage_t                stage;
    stage_t                next_stage;
    heat_guard_pkg::meas_t held;
    logic [15:0]           peak;
    logic [HEAT_W_L-1:0]   heat;
    logic [2:0]            cmp;
    logic                  stall;
    logic                  blk_now;
    logic [6:0]            control;
    logic [2:0]            force_code;
    logic [2:0]            group_sel;
    logic [15:0]           motor_in;
    logic [15:0]           grp [heat_guard_pkg::NUM_GROUPS][heat_guard_pkg::GRP_FIELDS];
    logic [4:0]            outs;
    logic [4:0]            outs_prev;
    logic [4:0]            irq_stat;
    logic [4:0]            irq_mask;
    logic [4:0]            cnt_clear;
    logic [4:0]            change;
    logic [31:0]           stamp_ms;
    logic [31:0]           cnt_val;
    logic [2:0]            mode;
    logic                  active;
    logic                  run;

    function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] c);
        logic [15:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    function automatic logic [15:0] to_fahr(input logic [15:0] c);
        logic [19:0] p;
        p = {4'h0, c} * 20'h00009;
        return 16'(p / 20'h00005) + 16'h0020;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Tick and blocking arrive from outside this clock domain.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            tick_meta  <= 1'b0;
            tick_sync  <= 1'b0;
            tick_prev  <= 1'b0;
            block_meta <= 1'b0;
            block_sync <= 1'b0;
        end else begin
            tick_meta  <= meas_tick;
            tick_sync  <= tick_meta;
            tick_prev  <= tick_sync;
            block_meta <= block_in;
            block_sync <= block_meta;
        end
    end

    assign mode   = control[heat_guard_pkg::CTL_MODE_LSB +: 3];
    assign active = control[heat_guard_pkg::CTL_ACTIVE_BIT];
    assign run    = active && (mode != heat_guard_pkg::MODE_OFF);

    // Register writes.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            control    <= {4'h0, heat_guard_pkg::MODE_ON};
            force_code <= heat_guard_pkg::FORCE_NORMAL;
            group_sel  <= 3'h0;
            motor_in   <= heat_guard_pkg::MOTOR_IN_RST;
            irq_mask   <= 5'h00;
            for (int g = 0; g < heat_guard_pkg::NUM_GROUPS; g++) begin
                grp[g][heat_guard_pkg::FLD_ALARM1]   <= heat_guard_pkg::ALARM1_RST;
                grp[g][heat_guard_pkg::FLD_ALARM2]   <= heat_guard_pkg::ALARM2_RST;
                grp[g][heat_guard_pkg::FLD_TRIP]     <= heat_guard_pkg::TRIP_RST;
                grp[g][heat_guard_pkg::FLD_OVERLOAD] <= heat_guard_pkg::OVERLOAD_RST;
            end
        end else if (bus.wr) begin
            unique case (bus.addr)
                heat_guard_pkg::REG_CONTROL: begin
                    if (bus.wdata[2:0] >= heat_guard_pkg::MODE_ON &&
                        bus.wdata[2:0] <= heat_guard_pkg::MODE_OFF) begin
                        control <= bus.wdata[6:0];
                    end
                end
                heat_guard_pkg::REG_FORCE: begin
                    if (bus.wdata[2:0] <= heat_guard_pkg::FORCE_TRIP) begin
                        force_code <= bus.wdata[2:0];
                    end
                end
                heat_guard_pkg::REG_GROUP_SEL: group_sel <= bus.wdata[2:0];
                heat_guard_pkg::REG_IRQ_MASK:  irq_mask  <= bus.wdata[4:0];
                heat_guard_pkg::REG_MOTOR_IN: begin
                    motor_in <= (bus.wdata[15:0] > heat_guard_pkg::MOTOR_IN_MAX) ?
                                heat_guard_pkg::MOTOR_IN_MAX : bus.wdata[15:0];
                end
                default: begin
                    if (bus.addr[7:6] == heat_guard_pkg::REG_GRP_BASE[7:6]) begin
                        grp[bus.addr[5:3]][bus.addr[2:1]] <= bus.wdata[15:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cnt_clear <= 5'h00;
        end else if (bus.wr && bus.addr == heat_guard_pkg::REG_CNT_CLEAR) begin
            cnt_clear <= bus.wdata[4:0];
        end else begin
            cnt_clear <= 5'h00;
        end
    end

    // Processing stages, one pass per measurement tick.
    always_comb begin
        next_stage = stage;
        unique case (stage)
            ST_IDLE:    if (tick_sync && !tick_prev) next_stage = ST_REPLICA;
            ST_REPLICA: next_stage = ST_COMPARE;
            ST_COMPARE: next_stage = ST_BLOCK;
            ST_BLOCK:   next_stage = ST_OUTPUT;
            ST_OUTPUT:  next_stage = ST_IDLE;
            default:    next_stage = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            stage <= ST_IDLE;
        end else begin
            stage <= next_stage;
        end
    end

    // Input magnitude processing: latch all 5 ms values together.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            held <= '0;
            peak <= 16'h0000;
        end else if (stage == ST_IDLE && next_stage == ST_REPLICA) begin
            held <= meas;
            peak <= max3(meas.phase_a_rms, meas.phase_b_rms, meas.phase_c_rms);
        end
    end

    // Simplified replica: heat moves toward the squared load per tick.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            heat  <= '0;
            stall <= 1'b0;
        end else if (stage == ST_REPLICA) begin
            logic [HEAT_W_L-1:0] target;
            logic [HEAT_W_L-1:0] step;
            logic                s;
            target = HEAT_W_L'({16'h0000, peak} * {16'h0000, peak} / 32'h0000_0064);
            s      = peak > grp[group_sel][heat_guard_pkg::FLD_OVERLOAD];
            if (target >= heat) begin
                step = (target - heat) >> (s ? heat_guard_pkg::HEAT_SHIFT_STALL :
                                               heat_guard_pkg::HEAT_SHIFT_LONG);
                heat <= heat + step;
            end else begin
                step = (heat - target) >> heat_guard_pkg::HEAT_SHIFT_LONG;
                heat <= heat - step;
            end
            stall <= s;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cmp <= 3'h0;
        end else if (stage == ST_COMPARE) begin
            cmp[0] <= heat >= HEAT_W_L'(grp[group_sel][heat_guard_pkg::FLD_ALARM1]);
            cmp[1] <= heat >= HEAT_W_L'(grp[group_sel][heat_guard_pkg::FLD_ALARM2]);
            cmp[2] <= heat >= HEAT_W_L'(grp[group_sel][heat_guard_pkg::FLD_TRIP]);
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            blk_now <= 1'b0;
        end else if (stage == ST_BLOCK) begin
            blk_now <= block_sync || mode == heat_guard_pkg::MODE_BLOCKED ||
                       mode == heat_guard_pkg::MODE_TEST_BLOCKED;
        end
    end

    // Output processing with forcing; order is trip, a1, a2, lockout, blocked.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            outs <= 5'h00;
        end else if (stage == ST_OUTPUT) begin
            if (!run) begin
                outs <= 5'h00;
            end else if (control[heat_guard_pkg::CTL_FORCE_EN] &&
                         force_code != heat_guard_pkg::FORCE_NORMAL) begin
                outs <= 5'h00;
                unique case (force_code)
                    heat_guard_pkg::FORCE_BLOCKED: outs[heat_guard_pkg::EV_BLOCKED] <= 1'b1;
                    heat_guard_pkg::FORCE_ALARM1:  outs[heat_guard_pkg::EV_ALARM1]  <= 1'b1;
                    heat_guard_pkg::FORCE_ALARM2:  outs[heat_guard_pkg::EV_ALARM2]  <= 1'b1;
                    heat_guard_pkg::FORCE_LOCKOUT: outs[heat_guard_pkg::EV_LOCKOUT] <= 1'b1;
                    default: outs <= 5'((1 << heat_guard_pkg::EV_TRIP) |
                                        (1 << heat_guard_pkg::EV_LOCKOUT));
                endcase
            end else if (blk_now) begin
                outs <= 5'h10;
            end else begin
                outs <= {1'b0, cmp[2], cmp[1], cmp[0], cmp[2]};
            end
        end
    end

    assign trip    = outs[heat_guard_pkg::EV_TRIP];
    assign alarm1  = outs[heat_guard_pkg::EV_ALARM1];
    assign alarm2  = outs[heat_guard_pkg::EV_ALARM2];
    assign lockout = outs[heat_guard_pkg::EV_LOCKOUT];
    assign blocked = outs[heat_guard_pkg::EV_BLOCKED];

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            outs_prev <= 5'h00;
        end else begin
            outs_prev <= outs;
        end
    end

    assign change = outs ^ outs_prev;

    // One event per cycle, lowest changed index wins; other changes in that cycle are dropped.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            event_out <= '0;
        end else begin
            event_out <= '0;
            for (int i = heat_guard_pkg::NUM_EVENTS - 1; i >= 0; i--) begin
                if (change[i]) begin
                    event_out.valid    <= 1'b1;
                    event_out.source   <= 3'(i);
                    event_out.on       <= outs[i];
                    event_out.stamp_ms <= stamp_ms;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            irq_stat <= 5'h00;
        end else if (bus.rd && bus.addr == heat_guard_pkg::REG_IRQ_STAT) begin
            irq_stat <= change & outs;
        end else begin
            irq_stat <= irq_stat | (change & outs);
        end
    end

    assign irq = |(irq_stat & irq_mask);

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            heat_temp <= 16'h0000;
        end else if (control[heat_guard_pkg::CTL_FAHR_BIT]) begin
            heat_temp <= to_fahr(held.ambient_temp + 16'(heat));
        end else begin
            heat_temp <= held.ambient_temp + 16'(heat);
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                heat_guard_pkg::REG_CONTROL:   rdata <= {25'h0, control};
                heat_guard_pkg::REG_FORCE:     rdata <= {29'h0, force_code};
                heat_guard_pkg::REG_GROUP_SEL: rdata <= {29'h0, group_sel};
                heat_guard_pkg::REG_STATUS:    rdata <= {25'h0, stall, run, outs};
                heat_guard_pkg::REG_IRQ_STAT:  rdata <= {27'h0, irq_stat};
                heat_guard_pkg::REG_IRQ_MASK:  rdata <= {27'h0, irq_mask};
                heat_guard_pkg::REG_STAMP:     rdata <= stamp_ms;
                heat_guard_pkg::REG_MOTOR_IN:  rdata <= {16'h0, motor_in};
                default: begin
                    if (bus.addr[7:6] == heat_guard_pkg::REG_GRP_BASE[7:6]) begin
                        rdata <= {16'h0, grp[bus.addr[5:3]][bus.addr[2:1]]};
                    end else if (bus.addr[7:5] == heat_guard_pkg::REG_CNT_BASE[7:5]) begin
                        rdata <= cnt_val;
                    end else begin
                        rdata <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    stamp_timer u_stamp (
        .clk      (clk),
        .rst_n    (rst_sync),
        .stamp_ms (stamp_ms),
        .ms_pulse ()
    );

    event_counter u_count (
        .clk   (clk),
        .rst_n (rst_sync),
        .rise  (change & outs),
        .clear (cnt_clear),
        .sel   (bus.addr[4:2]),
        .count (cnt_val)
    );
endmodule

// File: rtl/stamp_timer.sv
// Millisecond time stamp counter.
`timescale 1ns/1ns
module stamp_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    output logic [31:0]      stamp_ms,
    output logic             ms_pulse
);
    logic [15:0] div;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 16'h0000;
        end else if (div == 16'(heat_guard_pkg::STAMP_CYCLES - 1)) begin
            div <= 16'h0000;
        end else begin
            div <= div + 16'h0001;
        end
    end

    assign ms_pulse = (div == 16'(heat_guard_pkg::STAMP_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_ms <= 32'h0000_0000;
        end else if (ms_pulse) begin
            stamp_ms <= stamp_ms + 32'h0000_0001;
        end
    end
endmodule

// File: shared/heat_guard_pkg.sv
// Constants, register map and carrier types of the machine heat guard.
package heat_guard_pkg;

    localparam int CLK_HZ          = 10_000_000;
    localparam int TICK_MS         = 5;
    localparam int STAMP_MS        = 1;
    localparam int STAMP_CYCLES    = CLK_HZ / 1000 * STAMP_MS;
    localparam int TICK_STAMPS     = TICK_MS / STAMP_MS;

    localparam int NUM_GROUPS      = 8;
    localparam int HARMONICS       = 32;
    localparam int NUM_EVENTS      = 5;

    // Register offsets.
    localparam logic [7:0] REG_CONTROL   = 8'h00;
    localparam logic [7:0] REG_FORCE     = 8'h04;
    localparam logic [7:0] REG_GROUP_SEL = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0C;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h14;
    localparam logic [7:0] REG_CNT_CLEAR = 8'h18;
    localparam logic [7:0] REG_STAMP     = 8'h1C;
    localparam logic [7:0] REG_MOTOR_IN  = 8'h20;
    localparam logic [7:0] REG_GRP_BASE  = 8'h40;
    localparam logic [7:0] REG_CNT_BASE  = 8'h80;

    // Group setting fields: alarm1, alarm2 and trip limits, overload limit.
    localparam int GRP_FIELDS      = 4;
    localparam int FLD_ALARM1      = 0;
    localparam int FLD_ALARM2      = 1;
    localparam int FLD_TRIP        = 2;
    localparam int FLD_OVERLOAD    = 3;

    // Control register fields.
    localparam int CTL_MODE_LSB    = 0;
    localparam int CTL_ACTIVE_BIT  = 4;
    localparam int CTL_FAHR_BIT    = 5;
    localparam int CTL_FORCE_EN    = 6;

    localparam logic [2:0]  MODE_ON           = 3'h1;
    localparam logic [2:0]  MODE_BLOCKED      = 3'h2;
    localparam logic [2:0]  MODE_TEST         = 3'h3;
    localparam logic [2:0]  MODE_TEST_BLOCKED = 3'h4;
    localparam logic [2:0]  MODE_OFF          = 3'h5;

    localparam logic [2:0]  FORCE_NORMAL  = 3'h0;
    localparam logic [2:0]  FORCE_BLOCKED = 3'h1;
    localparam logic [2:0]  FORCE_ALARM1  = 3'h2;
    localparam logic [2:0]  FORCE_ALARM2  = 3'h3;
    localparam logic [2:0]  FORCE_LOCKOUT = 3'h4;
    localparam logic [2:0]  FORCE_TRIP    = 3'h5;

    // Motor nominal current in 0.1 A steps, 5000.0 A at most.
    localparam logic [15:0] MOTOR_IN_MAX  = 16'hC350;
    localparam logic [15:0] MOTOR_IN_RST  = 16'h000A;
    // Overload limit default 2.0 per unit in 0.1 steps.
    localparam logic [15:0] OVERLOAD_RST  = 16'h0014;
    localparam logic [15:0] ALARM1_RST    = 16'h0050;
    localparam logic [15:0] ALARM2_RST    = 16'h005A;
    localparam logic [15:0] TRIP_RST      = 16'h0064;

    // Heat image arithmetic.
    localparam int HEAT_W          = 24;
    localparam int HEAT_SHIFT_LONG = 10;
    localparam int HEAT_SHIFT_STALL = 6;
    localparam logic [HEAT_W-1:0] HEAT_FULL = 24'h0003E8;

    // Event index order in vectors.
    localparam int EV_TRIP    = 0;
    localparam int EV_ALARM1  = 1;
    localparam int EV_ALARM2  = 2;
    localparam int EV_LOCKOUT = 3;
    localparam int EV_BLOCKED = 4;

    typedef struct packed {
        logic [15:0] phase_a_rms;
        logic [15:0] phase_b_rms;
        logic [15:0] phase_c_rms;
        logic [15:0] positive_seq_current;
        logic [15:0] negative_seq_current;
        logic [15:0] ambient_temp;
    } meas_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic                  valid;
        logic [2:0]            source;
        logic                  on;
        logic [31:0]           stamp_ms;
    } event_t;

endpackage

// File: testbench/heat_guard_props.sv
// Port checks of the machine heat guard.
`timescale 1ns/1ns
module heat_guard_props (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire heat_guard_pkg::reg_req_t bus,
    input wire logic [31:0]              rdata,
    input wire heat_guard_pkg::event_t   event_out,
    input wire logic                     trip,
    input wire logic                     alarm1,
    input wire logic                     lockout,
    input wire logic                     blocked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_trip_event_on: assert property ($rose(trip) |=>
        event_out.valid && event_out.source == 3'h0 && event_out.on) else $error("trip on lost");
    a_trip_event_off: assert property ($fell(trip) |=>
        event_out.valid && event_out.source == 3'h0 && !event_out.on) else $error("trip off lost");
    a_alarm_event_on: assert property ($rose(alarm1) && $stable(trip) |=>
        event_out.valid && event_out.source == 3'h1 && event_out.on) else $error("alarm lost");
    a_event_one_pulse: assert property (event_out.valid |=> !event_out.valid)
        else $error("event pulse too long");
    a_block_event_cause: assert property (event_out.valid && event_out.source == 3'h4 |->
        $past(blocked) != $past(blocked, 2)) else $error("blocked event without change");
    a_event_source_legal: assert property (event_out.valid |-> event_out.source <= 3'h4)
        else $error("bad event source");
    a_lockout_follows_trip: assert property (trip |-> lockout)
        else $error("lockout differs from trip");
    a_rdata_holds: assert property (!$past(bus.rd) |-> $stable(rdata))
        else $error("read data moved");
endmodule

// File: testbench/machine_heat_guard_bench.sv
// Self-checking bench of the machine heat guard.
`timescale 1ns/1ns
module machine_heat_guard_bench;
    logic                     clk = 1'b0, rst_n = 1'b0, block_in = 1'b0, go = 1'b0, rd_q = 1'b0;
    heat_guard_pkg::reg_req_t bus = '0;
    heat_guard_pkg::meas_t    sample = '0, meas;
    heat_guard_pkg::event_t   event_out;
    logic                     meas_tick, trip, alarm1, alarm2, lockout, blocked, irq;
    logic [31:0]              rdata, rq[$];
    logic [15:0]              heat_temp, v;
    logic [3:0]               eq[$];
    logic [4:0]               outs;
    logic [2:0]               fc[4] = '{3'h1, 3'h2, 3'h3, 3'h5};
    logic [2:0]               src[4] = '{3'h4, 3'h1, 3'h2, 3'h0};
    int                       err_count = 0, num_checks = 0, cycles = 0;
    assign outs = {blocked, lockout, alarm2, alarm1, trip};
    always #50 clk = ~clk;
    machine_heat_guard u_dut (.clk, .rst_n, .meas, .meas_tick, .block_in, .bus, .rdata,
        .event_out, .trip, .alarm1, .alarm2, .lockout, .blocked, .heat_temp, .irq);
    meas_source u_src (.clk, .go, .sample, .meas, .meas_tick);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        rq.push_back(want);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic tick();
        sample.ambient_temp <= 16'($urandom_range(0, 99));
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    always @(posedge clk) rd_q <= bus.rd;
    always @(negedge clk) if (rd_q) check(rdata, rq.pop_front());
    always @(negedge clk) if (event_out.valid === 1'b1)
        check(32'({event_out.source, event_out.on}), 32'(eq.pop_front()));
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h77f0));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(heat_guard_pkg::REG_CONTROL, 32'h1);
        rd(heat_guard_pkg::REG_MOTOR_IN, 32'hA);
        rd(8'h3C, 32'h0);
        wr(heat_guard_pkg::REG_CONTROL, 32'h0);
        wr(heat_guard_pkg::REG_MOTOR_IN, 32'hFFFF);
        rd(heat_guard_pkg::REG_CONTROL, 32'h1);
        rd(heat_guard_pkg::REG_MOTOR_IN, {16'h0, heat_guard_pkg::MOTOR_IN_MAX});
        v = 16'($urandom) | 16'h0001;
        wr(8'h78, {16'h0, v});
        wr(heat_guard_pkg::REG_GROUP_SEL, 32'h7);
        rd(8'h78, {16'h0, v});
        wr(heat_guard_pkg::REG_CONTROL, 32'h11);
        wr(heat_guard_pkg::REG_FORCE, 32'h5);
        tick();
        check(32'(trip), 32'h0);
        check(32'(heat_temp), 32'(sample.ambient_temp));
        wr(heat_guard_pkg::REG_CONTROL, 32'h51);
        foreach (fc[i]) begin
            wr(heat_guard_pkg::REG_FORCE, 32'(fc[i]));
            eq.push_back({src[i], 1'b1});
            tick();
            check(32'(outs[src[i]]), 32'h1);
            check(32'(irq), 32'h0);
            wr(heat_guard_pkg::REG_FORCE, 32'h0);
            eq.push_back({src[i], 1'b0});
            tick();
        end
        wr(heat_guard_pkg::REG_IRQ_MASK, 32'h1F);
        check(32'(irq), 32'h1);
        rd(heat_guard_pkg::REG_IRQ_STAT, 32'h1F);
        check(32'(irq), 32'h0);
        for (int i = 0; i < 5; i++) rd(8'(8'h80 + i * 4), 32'h1);
        wr(heat_guard_pkg::REG_CNT_CLEAR, 32'h1F);
        rd(8'h80, 32'h0);
        block_in <= 1'b1;
        eq.push_back({3'h4, 1'b1});
        tick();
        check(32'(blocked), 32'h1);
        block_in <= 1'b0;
        eq.push_back({3'h4, 1'b0});
        tick();
        wr(heat_guard_pkg::REG_FORCE, 32'h7);
        rd(heat_guard_pkg::REG_FORCE, 32'h0);
        wr(heat_guard_pkg::REG_CONTROL, 32'h31);
        repeat (3) @(posedge clk);
        check(32'(heat_temp), 32'(sample.ambient_temp) * 9 / 5 + 32);
        check(32'(eq.size() + rq.size()), 32'h0);
        conclude();
    end
endmodule
bind machine_heat_guard heat_guard_props u_props (.clk, .rst_n, .bus, .rdata, .event_out,
    .trip, .alarm1, .lockout, .blocked);

// File: testbench/meas_source.sv
// Measurement front end model: one sample set with its update strobe.
`timescale 1ns/1ns
module meas_source (
    input  wire logic                  clk,
    input  wire logic                  go,
    input  wire heat_guard_pkg::meas_t sample,
    output heat_guard_pkg::meas_t      meas,
    output logic                       meas_tick
);
    logic [3:0] hold = 4'h0;
    initial meas = '0;
    initial meas_tick = 1'b0;
    // Currents are per unit of a motor nominal of one; loads are inverted every cycle once the hold ends.
    // Holds the set through the strobe, then lets the lines wander.
    always @(posedge clk) begin
        if (go) begin
            meas <= sample;
            hold <= 4'h5;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end else begin
            meas <= ~meas;
        end
        meas_tick <= go || hold > 4'h1;
    end
endmodule
